/* File: shared/pbp_pkg.sv */
// Purpose: Constants and types for the partner base-page upper word bank.
// Assumes: Registers are 16 bits wide, reached in management device 0x07.
// Notes: Field positions index the 16-bit register words.
`default_nettype none
package pbp_pkg;
  localparam logic [4:0] PBP_DEV_ADDR = 5'h07;
  localparam logic [15:0] PBP_LOW_ADDR = 16'h0205;
  localparam logic [15:0] PBP_MID_ADDR = 16'h0206;
  localparam logic [15:0] PBP_HIGH_ADDR = 16'h0207;
  localparam logic [15:0] PBP_MID_RESET = 16'h0000;
  localparam logic [15:0] PBP_HIGH_RESET = 16'h0000;
  // Field positions in the middle word.
  localparam int PBP_MID_LONG_REACH = 14;
  localparam int PBP_MID_GIGABIT = 7;
  localparam int PBP_MID_SR_FULL = 6;
  localparam int PBP_MID_FAST = 5;
  localparam int PBP_MID_MASTER = 4;
  // Field positions in the high word.
  localparam int PBP_HIGH_ENERGY = 14;
  localparam int PBP_HIGH_SWING_CAP = 13;
  localparam int PBP_HIGH_SWING_REQ = 12;
  localparam int PBP_HIGH_SR_HALF = 11;
  // Field position in the low word.
  localparam int PBP_LOW_FORCED = 12;
  // Implemented bits; all others are reserved and read as zero.
  localparam logic [15:0] PBP_MID_MASK = 16'h40f0;
  localparam logic [15:0] PBP_HIGH_MASK = 16'h7800;

  // One management register access request.
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] devAddr;
    logic [15:0] regAddr;
    logic [15:0] wrData;
  } pbp_req_t;

  // Read answer.
  typedef struct packed {
    logic valid;
    logic hit;
    logic [15:0] data;
  } pbp_rsp_t;
endpackage
`default_nettype wire

/* File: rtl/pbp_regs.sv */
// Purpose: Holds the partner base-page middle and high words as snapshots.
// Assumes: The management frame decoder presents one-cycle access requests.
// Notes: The low word itself lives elsewhere; only its read and its live forced flag are observed here.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Reading the low base-page word snapshots the middle and high words.
// - Middle and high word reads return the snapshot, never the live value.
// - Middle word is device 0x07 register 0x0206, resetting to zero.
// - High word is register 0x0207 in device 0x07, resetting to zero.
// - Middle bit 14 shows partner long-reach ability.
// - Middle bit 7 shows partner gigabit ability.
// - Middle bit 6 shows partner short-reach full-duplex ability.
// - Middle bit 5 shows partner fast ability.
// - Middle bit 4 shows partner role: 0 slave, 1 master.
// - High bit 14 shows partner energy-saving ability.
// - High bit 13 shows partner can transmit at high swing.
// - High bit 12 shows partner requests high swing.
// - High bit 11 shows partner short-reach half-duplex ability.
// - Low-word forced flag: role bit is preference (0) or forced (1).
// - Low swing if either lacks capability; else high if either requests.
module pbp_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire pbp_pkg::pbp_req_t req,
  input wire logic partnerLongReachAbility,
  input wire logic partnerGigabitAbility,
  input wire logic partnerShortReachFullDuplex,
  input wire logic partnerFastAbility,
  input wire logic partnerMasterSelect,
  input wire logic partnerRoleForcedLive,
  input wire logic partnerEnergySavingAbility,
  input wire logic partnerHighSwingCapable,
  input wire logic partnerHighSwingRequest,
  input wire logic partnerShortReachHalfDuplex,
  input wire logic localHighSwingCapable,
  input wire logic localHighSwingRequest,
  output var pbp_pkg::pbp_rsp_t rsp,
  output logic partnerRoleForced,
  output logic highSwingSelected
);

  logic [15:0] midLive;
  logic [15:0] highLive;
  logic [15:0] midWord_reg;
  logic [15:0] highWord_reg;
  logic forced_reg;
  logic swing_reg;
  logic lowRead;
  pbp_pkg::pbp_rsp_t rsp_reg;
  pbp_pkg::pbp_rsp_t rsp_next;

  // True when a request is a read of the given register in our device.
  function automatic logic isRead(input pbp_pkg::pbp_req_t r,
                                  input logic [15:0] a);
    isRead = r.valid && !r.write && r.devAddr == pbp_pkg::PBP_DEV_ADDR
             && r.regAddr == a;
  endfunction

  // Assemble the live words; reserved positions stay zero by construction.
  always_comb begin
    midLive = 16'h0000;
    highLive = 16'h0000;
    midLive[pbp_pkg::PBP_MID_LONG_REACH] = partnerLongReachAbility;
    midLive[pbp_pkg::PBP_MID_GIGABIT] = partnerGigabitAbility;
    midLive[pbp_pkg::PBP_MID_SR_FULL] = partnerShortReachFullDuplex;
    midLive[pbp_pkg::PBP_MID_FAST] = partnerFastAbility;
    midLive[pbp_pkg::PBP_MID_MASTER] = partnerMasterSelect;
    highLive[pbp_pkg::PBP_HIGH_ENERGY] = partnerEnergySavingAbility;
    highLive[pbp_pkg::PBP_HIGH_SWING_CAP] = partnerHighSwingCapable;
    highLive[pbp_pkg::PBP_HIGH_SWING_REQ] = partnerHighSwingRequest;
    highLive[pbp_pkg::PBP_HIGH_SR_HALF] = partnerShortReachHalfDuplex;
  end

  assign lowRead = isRead(req, pbp_pkg::PBP_LOW_ADDR);

  // Snapshot on a low-word read so that all three words form one page, even
  // if a new page arrives between the host's reads.
  always_ff @(posedge mclk) begin
    if (rst) begin
      midWord_reg <= pbp_pkg::PBP_MID_RESET;
      highWord_reg <= pbp_pkg::PBP_HIGH_RESET;
    end else if (lowRead) begin
      midWord_reg <= midLive & pbp_pkg::PBP_MID_MASK;
      highWord_reg <= highLive & pbp_pkg::PBP_HIGH_MASK;
    end
  end

  // Forced-role flag follows the low word's live value.
  always_ff @(posedge mclk) begin
    if (rst) begin
      forced_reg <= 1'b0;
    end else begin
      forced_reg <= partnerRoleForcedLive;
    end
  end

  // Transmit level resolution uses the live pages, not the snapshot, since
  // the snapshot only moves when software happens to read.
  always_ff @(posedge mclk) begin
    if (rst) begin
      swing_reg <= 1'b0;
    end else if (!partnerHighSwingCapable || !localHighSwingCapable) begin
      swing_reg <= 1'b0;
    end else begin
      swing_reg <= partnerHighSwingRequest | localHighSwingRequest;
    end
  end

  // Read decode; writes are acknowledged but change nothing.
  always_comb begin
    rsp_next = '0;
    if (req.valid) begin
      rsp_next.valid = 1'b1;
      if (isRead(req, pbp_pkg::PBP_MID_ADDR)) begin
        rsp_next.hit = 1'b1;
        rsp_next.data = midWord_reg;
      end else if (isRead(req, pbp_pkg::PBP_HIGH_ADDR)) begin
        rsp_next.hit = 1'b1;
        rsp_next.data = highWord_reg;
      end else if (req.devAddr == pbp_pkg::PBP_DEV_ADDR &&
                   (req.regAddr == pbp_pkg::PBP_MID_ADDR ||
                    req.regAddr == pbp_pkg::PBP_HIGH_ADDR)) begin
        rsp_next.hit = 1'b1;
      end
    end
  end

  // Answer register.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;
  assign partnerRoleForced = forced_reg;
  assign highSwingSelected = swing_reg;

  // Checks. Snapshot checks look one edge back, because the words load on
  // the very edge that takes the low-word read.
  sequence s_lowRead;
    lowRead;
  endsequence

  // Taken reads of the two mapped words, and the hit answer they earn.
  sequence s_midRead;
    isRead(req, pbp_pkg::PBP_MID_ADDR);
  endsequence
  sequence s_highRead;
    isRead(req, pbp_pkg::PBP_HIGH_ADDR);
  endsequence
  sequence s_hitAnswer;
    rsp.valid && rsp.hit;
  endsequence

  property p_snapMid;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> midWord_reg == ($past(midLive) & pbp_pkg::PBP_MID_MASK);
  endproperty
  a_snapMid: assert property (p_snapMid)
    else $error("mid snapshot wrong");

  property p_snapHigh;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> highWord_reg == ($past(highLive) & pbp_pkg::PBP_HIGH_MASK);
  endproperty
  a_snapHigh: assert property (p_snapHigh)
    else $error("high snapshot wrong");

  property p_hold;
    @(posedge mclk) disable iff (rst)
      !lowRead |=> $stable(midWord_reg) && $stable(highWord_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("snapshot moved");

  property p_midRead;
    @(posedge mclk) disable iff (rst)
      s_midRead |=> s_hitAnswer ##0 (rsp.data == $past(midWord_reg));
  endproperty
  a_midRead: assert property (p_midRead)
    else $error("mid read wrong");

  property p_highRead;
    @(posedge mclk) disable iff (rst)
      s_highRead |=> s_hitAnswer ##0 (rsp.data == $past(highWord_reg));
  endproperty
  a_highRead: assert property (p_highRead)
    else $error("high read wrong");

  // Anything outside the two mapped words is answered but never as a hit.
  property p_unmapped;
    @(posedge mclk) disable iff (rst)
      req.valid && !(req.devAddr == pbp_pkg::PBP_DEV_ADDR &&
        (req.regAddr == pbp_pkg::PBP_MID_ADDR ||
         req.regAddr == pbp_pkg::PBP_HIGH_ADDR)) |=>
        rsp.valid && !rsp.hit && rsp.data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access answered as hit");

  // No disable here: this one must run while reset is high.
  property p_resetWords;
    @(posedge mclk)
      rst |=> midWord_reg == pbp_pkg::PBP_MID_RESET &&
        highWord_reg == pbp_pkg::PBP_HIGH_RESET && !rsp.valid;
  endproperty
  a_resetWords: assert property (p_resetWords)
    else $error("reset left a word set");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
      (midWord_reg & ~pbp_pkg::PBP_MID_MASK) == 16'h0000 &&
      (highWord_reg & ~pbp_pkg::PBP_HIGH_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");

  // One check per reported field, two for long reach, each against the live bit one edge back.
  property p_longReach;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> midWord_reg[pbp_pkg::PBP_MID_LONG_REACH] ==
        $past(partnerLongReachAbility);
  endproperty
  a_longReach: assert property (p_longReach)
    else $error("long reach bit wrong");

  property p_gigabit;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> midWord_reg[pbp_pkg::PBP_MID_GIGABIT] ==
        $past(partnerGigabitAbility);
  endproperty
  a_gigabit: assert property (p_gigabit)
    else $error("gigabit bit wrong");

  property p_srFull;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> midWord_reg[pbp_pkg::PBP_MID_SR_FULL] ==
        $past(partnerShortReachFullDuplex);
  endproperty
  a_srFull: assert property (p_srFull)
    else $error("short reach full duplex bit wrong");

  property p_fast;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> midWord_reg[pbp_pkg::PBP_MID_FAST] ==
        $past(partnerFastAbility);
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast bit wrong");

  property p_master;
    @(posedge mclk) disable iff (rst)
      lowRead |=> midWord_reg[pbp_pkg::PBP_MID_MASTER] ==
        $past(partnerMasterSelect) &&
        midWord_reg[pbp_pkg::PBP_MID_LONG_REACH] ==
        $past(partnerLongReachAbility);
  endproperty
  a_master: assert property (p_master)
    else $error("role bit wrong");

  property p_energy;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> highWord_reg[pbp_pkg::PBP_HIGH_ENERGY] ==
        $past(partnerEnergySavingAbility);
  endproperty
  a_energy: assert property (p_energy)
    else $error("energy saving bit wrong");

  property p_swingCap;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> highWord_reg[pbp_pkg::PBP_HIGH_SWING_CAP] ==
        $past(partnerHighSwingCapable);
  endproperty
  a_swingCap: assert property (p_swingCap)
    else $error("swing capability bit wrong");

  property p_swingReq;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> highWord_reg[pbp_pkg::PBP_HIGH_SWING_REQ] ==
        $past(partnerHighSwingRequest);
  endproperty
  a_swingReq: assert property (p_swingReq)
    else $error("swing request bit wrong");

  property p_srHalf;
    @(posedge mclk) disable iff (rst)
      s_lowRead |=> highWord_reg[pbp_pkg::PBP_HIGH_SR_HALF] ==
        $past(partnerShortReachHalfDuplex);
  endproperty
  a_srHalf: assert property (p_srHalf)
    else $error("short reach half duplex bit wrong");

  // Sampled reset guards the edge on which a mid-run reset is released.
  property p_swingHigh;
    @(posedge mclk) disable iff (rst)
      !rst && partnerHighSwingCapable && localHighSwingCapable &&
        (partnerHighSwingRequest || localHighSwingRequest) |=>
        highSwingSelected;
  endproperty
  a_swingHigh: assert property (p_swingHigh)
    else $error("swing not high");

  property p_swingLow;
    @(posedge mclk) disable iff (rst)
      !(partnerHighSwingCapable && localHighSwingCapable) |=>
        !highSwingSelected;
  endproperty
  a_swingLow: assert property (p_swingLow)
    else $error("swing not low");

  // The forced flag copies the live bit with one edge of delay.
  property p_forced;
    @(posedge mclk) disable iff (rst)
      !rst |=> partnerRoleForced == $past(partnerRoleForcedLive);
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced flag wrong");

  property p_write;
    @(posedge mclk) disable iff (rst)
      req.valid && req.write |=> $stable(midWord_reg) &&
        $stable(highWord_reg) && rsp.data == 16'h0000;
  endproperty
  a_write: assert property (p_write)
    else $error("write changed word");

endmodule

`default_nettype wire

/* File: bench/pbp_host.sv */
// Purpose: Management host model that issues one register access at a time.
// Assumes: Requests are taken on the rising edge where valid is high.
// Notes: The answer is sampled at the falling edge after it lands.
`timescale 1ns/100ps
`default_nettype none
module pbp_host (
  input wire logic mclk,
  output var pbp_pkg::pbp_req_t req,
  input wire pbp_pkg::pbp_rsp_t rsp
);
  // The request bus starts idle so nothing is taken during reset.
  initial req = '0;

  // One access: hold the request for its taking edge, then take the answer
  // at the next falling edge, while the one-cycle answer still stands.
  task automatic access(input logic wr, input logic [4:0] dev,
                        input logic [15:0] addr, input logic [15:0] wd,
                        output pbp_pkg::pbp_rsp_t got);
    @(posedge mclk);
    req <= '{valid: 1'b1, write: wr, devAddr: dev, regAddr: addr,
             wrData: wd};
    @(posedge mclk);
    req <= '0;
    @(negedge mclk);
    got = rsp;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the partner base-page word bank.
// Assumes: Live page bits are held steady around each snapshot read.
// Notes: Expected words are built from the field position table below.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] live = '0;
  logic forcedLive = 1'b0;
  logic lcap = 1'b0;
  logic lreq = 1'b0;
  logic roleForced;
  logic swingSel;
  pbp_pkg::pbp_req_t req;
  pbp_pkg::pbp_rsp_t rsp;
  pbp_pkg::pbp_rsp_t got;
  logic [15:0] expMid;
  logic [15:0] expHigh;
  int err_count = 0;
  int tests_run = 0;
  int pos [9] = '{14, 7, 6, 5, 4, 14, 13, 12, 11};

  // Free-running management clock.
  always #5 mclk = ~mclk;

  pbp_regs u_pbp_regs (.mclk(mclk), .rst(rst), .req(req),
    .partnerLongReachAbility(live[0]), .partnerGigabitAbility(live[1]),
    .partnerShortReachFullDuplex(live[2]), .partnerFastAbility(live[3]),
    .partnerMasterSelect(live[4]), .partnerRoleForcedLive(forcedLive),
    .partnerEnergySavingAbility(live[5]),
    .partnerHighSwingCapable(live[6]), .partnerHighSwingRequest(live[7]),
    .partnerShortReachHalfDuplex(live[8]), .localHighSwingCapable(lcap),
    .localHighSwingRequest(lreq), .rsp(rsp),
    .partnerRoleForced(roleForced), .highSwingSelected(swingSel));
  pbp_host u_pbp_host (.mclk(mclk), .req(req), .rsp(rsp));

  task automatic rd(input logic [4:0] dev, input logic [15:0] a);
    u_pbp_host.access(1'b0, dev, a, 16'h0000, got);
  endtask

  // Drive a page, read the low word to snapshot it, and work out the words.
  task automatic capture(input logic [8:0] v);
    @(posedge mclk);
    live <= v;
    expMid = 16'h0000;
    expHigh = 16'h0000;
    for (int i = 0; i < 9; i++) begin
      if (v[i] && i < 5) expMid[pos[i]] = 1'b1;
      if (v[i] && i >= 5) expHigh[pos[i]] = 1'b1;
    end
    rd(5'h07, pbp_pkg::PBP_LOW_ADDR);
    `CHK("low", 2'b10, {got.valid, got.hit})
  endtask

  task automatic chk_words(input logic [15:0] m, input logic [15:0] h);
    rd(5'h07, pbp_pkg::PBP_MID_ADDR);
    `CHK("mid", {2'b11, m}, {got.valid, got.hit, got.data})
    rd(5'h07, pbp_pkg::PBP_HIGH_ADDR);
    `CHK("high", {2'b11, h}, {got.valid, got.hit, got.data})
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    end_sim();
  end

  // Main sequence of register accesses and status checks.
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    chk_words(16'h0000, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      capture(9'h001 << i);
      chk_words(expMid, expHigh);
    end
    $display("test field walk done");
    capture(9'h1ff);
    @(posedge mclk);
    live <= 9'h000;
    chk_words(expMid, expHigh);
    u_pbp_host.access(1'b1, 5'h07, pbp_pkg::PBP_MID_ADDR, 16'h0000, got);
    `CHK("wr mid", 1'b1, got.hit)
    u_pbp_host.access(1'b1, 5'h07, pbp_pkg::PBP_HIGH_ADDR, 16'hffff, got);
    `CHK("wr high", 1'b1, got.hit)
    chk_words(expMid, expHigh);
    rd(5'h01, pbp_pkg::PBP_MID_ADDR);
    `CHK("bad dev", 18'h20000, got)
    rd(5'h07, 16'h0208);
    `CHK("bad reg", 18'h20000, got)
    $display("test snapshot and writes done");
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk);
      {lcap, lreq, live[6], live[7]} <= k[3:0];
      forcedLive <= k[0] ^ k[2];
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      `CHK("forced", k[0] ^ k[2], roleForced)
      `CHK("swing", k[3] & k[1] & (k[2] | k[0]), swingSel)
    end
    $display("test swing resolution done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("swing in reset", 1'b0, swingSel)
    `CHK("answer in reset", 1'b0, rsp.valid)
    @(posedge mclk);
    rst <= 1'b0;
    chk_words(16'h0000, 16'h0000);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
